// ### include/tmr_pkg.sv
// Types shared by the timer design files
package tmr_pkg;
   typedef enum logic [2:0] {
      TMR_SRC_STOP = 3'h0,
      TMR_SRC_DIV1 = 3'h1,
      TMR_SRC_DIV8 = 3'h2,
      TMR_SRC_DIV64 = 3'h3,
      TMR_SRC_DIV256 = 3'h4,
      TMR_SRC_DIV1024 = 3'h5,
      TMR_SRC_PIN_FALL = 3'h6,
      TMR_SRC_PIN_RISE = 3'h7
   } tmr_clk_src_type;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tmr_io_req_type;

   typedef struct packed {
      logic capture;
      logic cmp_b;
      logic cmp_a;
      logic ovf;
   } tmr_irq_type;
endpackage

// ### include/tmr_regs.svh
// Register offsets, field positions, reset values and counts of the timer
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_OFF_FLAGS 6'h0B
`define TMR_OFF_ENABLES 6'h0C
`define TMR_OFF_FORCE 6'h22
`define TMR_OFF_CAP_LO 6'h24
`define TMR_OFF_CAP_HI 6'h25
`define TMR_OFF_CMPB_LO 6'h28
`define TMR_OFF_CMPB_HI 6'h29
`define TMR_OFF_CMPA_LO 6'h2A
`define TMR_OFF_CMPA_HI 6'h2B
`define TMR_OFF_CNT_LO 6'h2C
`define TMR_OFF_CNT_HI 6'h2D
`define TMR_OFF_CTRL_B 6'h2E
`define TMR_OFF_CTRL_A 6'h2F
`define TMR_BIT_CAP 5
`define TMR_BIT_CMPB 2
`define TMR_BIT_CMPA 1
`define TMR_BIT_OVF 0
`define TMR_BIT_FORCE_A 7
`define TMR_BIT_FORCE_B 6
`define TMR_BIT_EDGE 6
`define TMR_BIT_CMP_SRC 2
`define TMR_CTRL_A_MASK 8'hF7
`define TMR_CTRL_B_MASK 8'hDF
`define TMR_RESET_BYTE 8'h00
`define TMR_MAX 16'hFFFF
`define TMR_TOP_8 16'h00FF
`define TMR_TOP_9 16'h01FF
`define TMR_TOP_10 16'h03FF
`define TMR_PRESC_W 10
`endif

// ### rtl/tmr_clk_gen.sv
// Timer tick generator: free-running prescaler and count pin edge detector
`timescale 1ns/1ps
`default_nettype none
`include "tmr_regs.svh"
module tmr_clk_gen
   import tmr_pkg::*;
#(
   parameter int PRESC_W = `TMR_PRESC_W
)(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire tmr_clk_src_type clk_src,
   input wire logic count_input_pin,
   output logic timer_tick
);
   logic [PRESC_W-1:0] presc_ff, nxt_presc;
   logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
   logic nxt_s1, nxt_s2, nxt_s3;

   // Tap is active when all bits below the divisor are ones
   function automatic logic tap(input logic [PRESC_W-1:0] p, input int w);
      logic [PRESC_W-1:0] m;
      m = PRESC_W'((1 << w) - 1);
      return (p & m) == m;
   endfunction

   // Pad level is sampled whatever the pin direction
   always_comb begin
      nxt_presc = presc_ff + 1'b1;
      nxt_s1 = count_input_pin;
      nxt_s2 = pin_s1_ff;
      nxt_s3 = pin_s2_ff;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         presc_ff <= '0;
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         pin_s3_ff <= 1'b0;
      end else begin
         presc_ff <= nxt_presc;
         pin_s1_ff <= nxt_s1;
         pin_s2_ff <= nxt_s2;
         pin_s3_ff <= nxt_s3;
      end
   end

   always_comb begin
      case (clk_src)
         TMR_SRC_DIV1: timer_tick = 1'b1;
         TMR_SRC_DIV8: timer_tick = tap(presc_ff, 3);
         TMR_SRC_DIV64: timer_tick = tap(presc_ff, 6);
         TMR_SRC_DIV256: timer_tick = tap(presc_ff, 8);
         TMR_SRC_DIV1024: timer_tick = tap(presc_ff, 10);
         TMR_SRC_PIN_FALL: timer_tick = !pin_s2_ff && pin_s3_ff;
         TMR_SRC_PIN_RISE: timer_tick = pin_s2_ff && !pin_s3_ff;
         default: timer_tick = 1'b0;
      endcase
   end

   chk_stop_no_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clk_src == TMR_SRC_STOP |-> !timer_tick)
      else $error("tick while stopped");
   chk_rise_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_src == TMR_SRC_PIN_RISE) && $rose(pin_s2_ff) |-> timer_tick)
      else $error("rising pin edge gave no tick");
endmodule // tmr_clk_gen
`default_nettype wire

// ### rtl/tmr_core.sv
// 16-bit timer/counter registers, counter, compare, capture and flags
// Functional notes
// - Source code 0 stops counter; codes 1-5 divide clock by 1,8,64,256,1024.
// - Code 6 counts falling count pin edges, code 7 rising edges.
// - Count pin edges count even when the pin is an output.
// - Force compare bits act only in non-PWM waveform modes.
// - Force compare makes an immediate match using the current output action.
// - Forced match raises no interrupt and never clears the counter.
// - Force compare bits are write-only strobes and read back zero.
// - Unused force bits and reserved mask/flag bits read zero.
// - Counter read and written as two bytes via shared high-byte holding register.
// - Counter write blocks compare matches on the next timer tick.
// - Both compare values are compared continuously with the counter.
// - Compare writes go through holding byte; both bytes update together.
// - Capture loads counter on pin or comparator edge; may be top.
// - Capture reads use the holding byte so both bytes match.
// - Interrupt asks only when enable, global enable and flag are set.
// - Capture flag sets on capture, or at top when capture is top.
// - Compare flag sets on the timer tick after the match cycle.
// - Forced compare leaves the compare flag unchanged.
// - Overflow flag sets at MAX in normal/clear modes, else at top.
// - Flags clear on vector execution or on writing one.
// - With capture as top, capture input is disconnected.
// - Non-PWM actions: 00 off, 01 toggle, 10 clear, 11 set.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_regs.svh"
module tmr_core
   import tmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire tmr_io_req_type io_req,
   output logic [7:0] io_rd_data,
   input wire logic irq_global_en,
   input wire tmr_irq_type irq_ack,
   output tmr_irq_type irq_req,
   input wire logic count_input_pin,
   input wire logic capture_input_pin,
   input wire logic analog_cmp_out,
   output logic wave_out_a,
   output logic wave_oe_a,
   output logic wave_out_b,
   output logic wave_oe_b
);
   logic [7:0] ctrl_a_ff, nxt_ctrl_a, ctrl_b_ff, nxt_ctrl_b;
   logic [7:0] temp_ff, nxt_temp, rd_ff, nxt_rd;
   logic [15:0] cnt_ff, nxt_cnt, ocra_ff, nxt_ocra;
   logic [15:0] ocrb_ff, nxt_ocrb, icr_ff, nxt_icr;
   tmr_irq_type flags_ff, nxt_flags, en_ff, nxt_en, set_v, clr_v;
   logic block_ff, nxt_block, cap_prev_ff, nxt_cap_prev;
   logic wave_a_ff, nxt_wave_a, wave_b_ff, nxt_wave_b;
   logic timer_tick, non_pwm, icr_top, cap_src, cap_evt, top_hit;
   logic hit_a, hit_b, force_a, force_b;
   logic [3:0] wave_mode_select;
   logic [15:0] top_val;
   logic [1:0] compare_output_action_a, compare_output_action_b;

   function automatic logic hit(input tmr_io_req_type r,
                                input logic [5:0] off);
      return r.addr == off;
   endfunction

   // Output level after a match for a non-PWM action code
   function automatic logic act(input logic [1:0] com, input logic cur);
      case (com)
         2'h1: return !cur;
         2'h2: return 1'b0;
         2'h3: return 1'b1;
         default: return cur;
      endcase
   endfunction

   tmr_clk_gen u_clk_gen (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_src(tmr_clk_src_type'(ctrl_b_ff[2:0])),
      .count_input_pin(count_input_pin),
      .timer_tick(timer_tick)
   );

   assign wave_mode_select = {ctrl_b_ff[4:3], ctrl_a_ff[1:0]};
   assign compare_output_action_a = ctrl_a_ff[7:6];
   assign compare_output_action_b = ctrl_a_ff[5:4];
   assign non_pwm = (wave_mode_select == 4'h0) ||
                    (wave_mode_select == 4'h4) ||
                    (wave_mode_select == 4'hC);
   assign icr_top = (wave_mode_select == 4'h8) ||
                    (wave_mode_select == 4'hA) ||
                    (wave_mode_select == 4'hC) ||
                    (wave_mode_select == 4'hE);

   always_comb begin
      case (wave_mode_select)
         4'h1, 4'h5: top_val = `TMR_TOP_8;
         4'h2, 4'h6: top_val = `TMR_TOP_9;
         4'h3, 4'h7: top_val = `TMR_TOP_10;
         4'h4, 4'h9, 4'hB, 4'hF: top_val = ocra_ff;
         4'h8, 4'hA, 4'hC, 4'hE: top_val = icr_ff;
         default: top_val = `TMR_MAX;
      endcase
   end

   // Capture source edge; disconnected when capture is top
   assign cap_src = ctrl_a_ff[`TMR_BIT_CMP_SRC] ? analog_cmp_out :
                    capture_input_pin;
   assign cap_evt = !icr_top && (ctrl_b_ff[`TMR_BIT_EDGE] ?
                    (cap_src && !cap_prev_ff) :
                    (!cap_src && cap_prev_ff));
   assign top_hit = timer_tick && (cnt_ff == top_val);

   // Match seen in the previous timer cycle, unless blocked
   assign hit_a = timer_tick && !block_ff && (cnt_ff == ocra_ff);
   assign hit_b = timer_tick && !block_ff && (cnt_ff == ocrb_ff);
   assign force_a = io_req.wr && hit(io_req, `TMR_OFF_FORCE) &&
                    io_req.wdata[`TMR_BIT_FORCE_A] && non_pwm;
   assign force_b = io_req.wr && hit(io_req, `TMR_OFF_FORCE) &&
                    io_req.wdata[`TMR_BIT_FORCE_B] && non_pwm;

   // Hardware set takes priority over any clear in the same cycle
   always_comb begin
      set_v.capture = icr_top ? top_hit : cap_evt;
      set_v.cmp_b = hit_b;
      set_v.cmp_a = hit_a;
      set_v.ovf = non_pwm ? (timer_tick && cnt_ff == `TMR_MAX) :
                  top_hit;
      clr_v = irq_ack;
      if (io_req.wr && hit(io_req, `TMR_OFF_FLAGS)) begin
         clr_v.capture = irq_ack.capture || io_req.wdata[`TMR_BIT_CAP];
         clr_v.cmp_b = irq_ack.cmp_b || io_req.wdata[`TMR_BIT_CMPB];
         clr_v.cmp_a = irq_ack.cmp_a || io_req.wdata[`TMR_BIT_CMPA];
         clr_v.ovf = irq_ack.ovf || io_req.wdata[`TMR_BIT_OVF];
      end
      nxt_flags = (flags_ff & ~clr_v) | set_v;
   end

   // Counter, compare, capture and holding byte
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_ocra = ocra_ff;
      nxt_ocrb = ocrb_ff;
      nxt_icr = icr_ff;
      nxt_temp = temp_ff;
      nxt_ctrl_a = ctrl_a_ff;
      nxt_ctrl_b = ctrl_b_ff;
      nxt_en = en_ff;
      nxt_cap_prev = cap_src;
      nxt_block = timer_tick ? 1'b0 : block_ff;
      if (timer_tick) begin
         // Forced strobes never reach this wrap, so they never clear
         nxt_cnt = (cnt_ff == top_val) ? 16'h0000 : cnt_ff + 16'h0001;
      end
      if (cap_evt) begin
         nxt_icr = cnt_ff;
      end
      if (io_req.wr) begin
         if (hit(io_req, `TMR_OFF_CNT_HI) || hit(io_req, `TMR_OFF_CMPA_HI) ||
             hit(io_req, `TMR_OFF_CMPB_HI) || hit(io_req, `TMR_OFF_CAP_HI)) begin
            nxt_temp = io_req.wdata;
         end else if (hit(io_req, `TMR_OFF_CNT_LO)) begin
            nxt_cnt = {temp_ff, io_req.wdata};
            nxt_block = 1'b1;
         end else if (hit(io_req, `TMR_OFF_CMPA_LO)) begin
            nxt_ocra = {temp_ff, io_req.wdata};
         end else if (hit(io_req, `TMR_OFF_CMPB_LO)) begin
            nxt_ocrb = {temp_ff, io_req.wdata};
         end else if (hit(io_req, `TMR_OFF_CAP_LO)) begin
            nxt_icr = {temp_ff, io_req.wdata};
         end else if (hit(io_req, `TMR_OFF_CTRL_A)) begin
            nxt_ctrl_a = io_req.wdata & `TMR_CTRL_A_MASK;
         end else if (hit(io_req, `TMR_OFF_CTRL_B)) begin
            nxt_ctrl_b = io_req.wdata & `TMR_CTRL_B_MASK;
         end else if (hit(io_req, `TMR_OFF_ENABLES)) begin
            nxt_en.capture = io_req.wdata[`TMR_BIT_CAP];
            nxt_en.cmp_b = io_req.wdata[`TMR_BIT_CMPB];
            nxt_en.cmp_a = io_req.wdata[`TMR_BIT_CMPA];
            nxt_en.ovf = io_req.wdata[`TMR_BIT_OVF];
         end
      end
      // Counter or capture low byte read latches the high byte of the same moment
      if (io_req.rd && hit(io_req, `TMR_OFF_CNT_LO)) begin
         nxt_temp = cnt_ff[15:8];
      end else if (io_req.rd && hit(io_req, `TMR_OFF_CAP_LO)) begin
         nxt_temp = icr_ff[15:8];
      end
   end

   // Read data; write-only and reserved bits return zero
   always_comb begin
      nxt_rd = rd_ff;
      if (io_req.rd) begin
         if (hit(io_req, `TMR_OFF_FLAGS)) begin
            nxt_rd = {2'h0, flags_ff.capture, 2'h0, flags_ff.cmp_b,
                      flags_ff.cmp_a, flags_ff.ovf};
         end else if (hit(io_req, `TMR_OFF_ENABLES)) begin
            nxt_rd = {2'h0, en_ff.capture, 2'h0, en_ff.cmp_b,
                      en_ff.cmp_a, en_ff.ovf};
         end else if (hit(io_req, `TMR_OFF_CNT_LO)) begin
            nxt_rd = cnt_ff[7:0];
         end else if (hit(io_req, `TMR_OFF_CAP_LO)) begin
            nxt_rd = icr_ff[7:0];
         end else if (hit(io_req, `TMR_OFF_CNT_HI) ||
                      hit(io_req, `TMR_OFF_CAP_HI)) begin
            nxt_rd = temp_ff;
         end else if (hit(io_req, `TMR_OFF_CMPA_LO)) begin
            nxt_rd = ocra_ff[7:0];
         end else if (hit(io_req, `TMR_OFF_CMPA_HI)) begin
            nxt_rd = ocra_ff[15:8];
         end else if (hit(io_req, `TMR_OFF_CMPB_LO)) begin
            nxt_rd = ocrb_ff[7:0];
         end else if (hit(io_req, `TMR_OFF_CMPB_HI)) begin
            nxt_rd = ocrb_ff[15:8];
         end else if (hit(io_req, `TMR_OFF_CTRL_A)) begin
            nxt_rd = ctrl_a_ff;
         end else if (hit(io_req, `TMR_OFF_CTRL_B)) begin
            nxt_rd = ctrl_b_ff;
         end else begin
            nxt_rd = `TMR_RESET_BYTE;
         end
      end
   end

   // Waveform outputs; PWM shaping is not modelled, so outputs hold there
   always_comb begin
      nxt_wave_a = wave_a_ff;
      nxt_wave_b = wave_b_ff;
      if (non_pwm && (hit_a || force_a)) begin
         nxt_wave_a = act(compare_output_action_a, wave_a_ff);
      end
      if (non_pwm && (hit_b || force_b)) begin
         nxt_wave_b = act(compare_output_action_b, wave_b_ff);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_a_ff <= `TMR_RESET_BYTE;
         ctrl_b_ff <= `TMR_RESET_BYTE;
         temp_ff <= `TMR_RESET_BYTE;
         rd_ff <= `TMR_RESET_BYTE;
         cnt_ff <= 16'h0000;
         ocra_ff <= 16'h0000;
         ocrb_ff <= 16'h0000;
         icr_ff <= 16'h0000;
         flags_ff <= '0;
         en_ff <= '0;
         block_ff <= 1'b0;
         cap_prev_ff <= 1'b0;
         wave_a_ff <= 1'b0;
         wave_b_ff <= 1'b0;
      end else begin
         ctrl_a_ff <= nxt_ctrl_a;
         ctrl_b_ff <= nxt_ctrl_b;
         temp_ff <= nxt_temp;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
         ocra_ff <= nxt_ocra;
         ocrb_ff <= nxt_ocrb;
         icr_ff <= nxt_icr;
         flags_ff <= nxt_flags;
         en_ff <= nxt_en;
         block_ff <= nxt_block;
         cap_prev_ff <= nxt_cap_prev;
         wave_a_ff <= nxt_wave_a;
         wave_b_ff <= nxt_wave_b;
      end
   end

   assign io_rd_data = rd_ff;
   assign irq_req = flags_ff & en_ff & {4{irq_global_en}};
   assign wave_out_a = wave_a_ff;
   assign wave_out_b = wave_b_ff;
   assign wave_oe_a = compare_output_action_a != 2'h0;
   assign wave_oe_b = compare_output_action_b != 2'h0;

   // Bytes spaced by one idle bus cycle, so nothing else touches the hold
   sequence s_cmpa_write;
      io_req.wr && hit(io_req, `TMR_OFF_CMPA_HI) ##1
      !io_req.wr && !io_req.rd ##1
      io_req.wr && hit(io_req, `TMR_OFF_CMPA_LO);
   endsequence

   sequence s_cnt_write;
      io_req.wr && hit(io_req, `TMR_OFF_CNT_LO);
   endsequence

   chk_cmpa_paired: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_cmpa_write |=> ocra_ff == {$past(io_req.wdata, 3),
                                   $past(io_req.wdata)})
      else $error("compare A bytes not paired");
   chk_force_no_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      force_a && !hit_a && !flags_ff.cmp_a |=> !flags_ff.cmp_a)
      else $error("forced compare set flag");
   chk_pwm_force_idle: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      !non_pwm && !timer_tick |=> $stable(wave_out_a))
      else $error("PWM mode force changed output");
   chk_write_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_cnt_write |=> block_ff)
      else $error("counter write did not arm match block");
   chk_block_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
      block_ff && timer_tick |-> !hit_a && !hit_b)
      else $error("match not blocked after counter write");
   chk_flag_w1c: assert property (@(posedge clk_sys) disable iff (!rst_n)
      io_req.wr && hit(io_req, `TMR_OFF_FLAGS) &&
      io_req.wdata[`TMR_BIT_OVF] && !set_v.ovf |=> !flags_ff.ovf)
      else $error("overflow flag not cleared");
   chk_flag_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      flags_ff.cmp_a && !irq_ack.cmp_a && !(io_req.wr &&
      hit(io_req, `TMR_OFF_FLAGS) && io_req.wdata[`TMR_BIT_CMPA])
      |=> flags_ff.cmp_a)
      else $error("compare A flag lost");
   chk_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      irq_req.ovf |-> flags_ff.ovf && en_ff.ovf && irq_global_en)
      else $error("overflow request without cause");
   chk_cmp_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timer_tick && !block_ff && cnt_ff == ocrb_ff |=> flags_ff.cmp_b)
      else $error("compare B flag not set");
   chk_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      io_req.rd && hit(io_req, `TMR_OFF_FLAGS) |=>
      io_rd_data[7:6] == 2'h0 && io_rd_data[4:3] == 2'h0)
      else $error("reserved flag bits not zero");
   chk_force_read_zero: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      io_req.rd && hit(io_req, `TMR_OFF_FORCE) |=> io_rd_data == 8'h00)
      else $error("force register read non-zero");
   chk_capture_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cap_evt && !io_req.wr |=> icr_ff == $past(cnt_ff))
      else $error("capture did not load counter");
   chk_tov_normal: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wave_mode_select == 4'h0 && timer_tick && cnt_ff == `TMR_MAX &&
      !io_req.wr |=> flags_ff.ovf && cnt_ff == 16'h0000)
      else $error("overflow not flagged");
endmodule // tmr_core
`default_nettype wire

// ### sim/testbench.sv
// Self-checking testbench for the timer core register interface
`timescale 1ns/1ps
`default_nettype none
`include "tmr_regs.svh"
module testbench
   import tmr_pkg::*;
;
   logic clk_sys;
   logic rst_n;
   tmr_io_req_type io_req;
   logic [7:0] io_rd_data;
   logic irq_global_en;
   tmr_irq_type irq_ack;
   tmr_irq_type irq_req;
   logic count_input_pin;
   logic capture_input_pin;
   logic analog_cmp_out;
   logic wave_out_a;
   logic wave_oe_a;
   logic wave_out_b;
   logic wave_oe_b;
   int errors;
   int n_compared;
   logic [15:0] rv;
   logic [7:0] d8;
   logic ea;
   int lo;
   int hi;
   int sh [5] = '{0, 3, 6, 8, 10};

   tmr_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .io_req(io_req),
      .io_rd_data(io_rd_data), .irq_global_en(irq_global_en),
      .irq_ack(irq_ack), .irq_req(irq_req),
      .count_input_pin(count_input_pin),
      .capture_input_pin(capture_input_pin),
      .analog_cmp_out(analog_cmp_out), .wave_out_a(wave_out_a),
      .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b),
      .wave_oe_b(wave_oe_b));

   tmr_pin_model u_pins (.clk_sys(clk_sys),
      .count_input_pin(count_input_pin),
      .capture_input_pin(capture_input_pin));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held through its taking edge, released one step later
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      io_req = {a, d, 2'b10};
      step();
      io_req = '0;
      step();
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      io_req = {a, 8'h00, 2'b01};
      step();
      io_req = '0;
      step();
      d = io_rd_data;
   endtask

   // High byte goes to the holding byte first, low byte commits both
   task automatic wr16(input logic [5:0] a, input logic [15:0] v);
      wr(a + 6'h01, v[15:8]);
      wr(a, v[7:0]);
   endtask

   // Low byte first so the high byte comes from the same moment
   task automatic rd16(input logic [5:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + 6'h01, v[15:8]);
   endtask

   // Counter rewritten only while stopped; the block still drops the match on the first tick
   task automatic run(input logic [2:0] src, input int n);
      wr(`TMR_OFF_CTRL_B, {5'h00, src});
      repeat (n) @(posedge clk_sys);
      #1;
      wr(`TMR_OFF_CTRL_B, 8'h00);
   endtask

   task automatic tend(input string name);
      $display("test %s done at %0t", name, $time);
   endtask

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Whole run is about 11k cycles; limit is 50k cycles
   initial begin
      #400000;
      errors++;
      final_report();
   end

   initial begin
      errors = 0;
      n_compared = 0;
      rst_n = 1'b0;
      io_req = '0;
      irq_global_en = 1'b0;
      irq_ack = '0;
      analog_cmp_out = 1'b0;
      repeat (16) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      step();
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0000);
      wr(`TMR_OFF_FLAGS, 8'hFF);
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0000);
      wr(`TMR_OFF_ENABLES, 8'hFF);
      rd(`TMR_OFF_ENABLES, d8);
      chk(16'(d8), 16'h0027);
      wr(`TMR_OFF_FORCE, 8'hFF);
      rd(`TMR_OFF_FORCE, d8);
      chk(16'(d8), 16'h0000);
      rd(6'h01, d8);
      chk(16'(d8), 16'h0000);
      tend("reset and reserved bits");
      wr16(`TMR_OFF_CNT_LO, 16'h1234);
      rd16(`TMR_OFF_CNT_LO, rv);
      chk(rv, 16'h1234);
      wr16(`TMR_OFF_CMPA_LO, 16'hABCD);
      wr16(`TMR_OFF_CMPB_LO, 16'h5AA5);
      rd16(`TMR_OFF_CMPA_LO, rv);
      chk(rv, 16'hABCD);
      rd16(`TMR_OFF_CMPB_LO, rv);
      chk(rv, 16'h5AA5);
      tend("16-bit access");
      for (int i = 1; i <= 5; i++) begin
         wr16(`TMR_OFF_CNT_LO, 16'h0000);
         run(3'(i), 2048);
         rd16(`TMR_OFF_CNT_LO, rv);
         lo = (2048 >> sh[i - 1]) - 1;
         hi = (2048 >> sh[i - 1]) + 4;
         chk(16'(int'(rv) >= lo && int'(rv) <= hi), 16'h0001);
      end
      tend("prescaler taps");
      wr16(`TMR_OFF_CMPA_LO, 16'h0010);
      wr16(`TMR_OFF_CMPB_LO, 16'h0000);
      wr(`TMR_OFF_ENABLES, 8'h02);
      irq_global_en = 1'b1;
      wr16(`TMR_OFF_CNT_LO, 16'h0000);
      run(3'h1, 40);
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0002);
      chk(16'(irq_req), 16'h0002);
      wr(`TMR_OFF_FLAGS, 8'h00);
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0002);
      irq_global_en = 1'b0;
      step();
      chk(16'(irq_req), 16'h0000);
      wr(`TMR_OFF_FLAGS, 8'h02);
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0000);
      wr16(`TMR_OFF_CNT_LO, 16'hFFF8);
      run(3'h1, 40);
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0007);
      irq_ack = 4'b0111;
      step();
      irq_ack = '0;
      step();
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0000);
      tend("flags and interrupts");
      ea = 1'b0;
      for (int c = 1; c < 4; c++) begin
         wr(`TMR_OFF_CTRL_A, {2'(c), 2'(c), 4'h0});
         wr(`TMR_OFF_FORCE, 8'hC0);
         ea = (c == 1) ? ~ea : 1'(c);
         chk(16'({wave_oe_a, wave_oe_b, wave_out_a, wave_out_b}),
            16'({2'b11, ea, ea}));
      end
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0000);
      wr(`TMR_OFF_CTRL_A, 8'hA1);
      wr(`TMR_OFF_FORCE, 8'hC0);
      chk(16'({wave_out_a, wave_out_b}), 16'h0003);
      wr(`TMR_OFF_FORCE, 8'h00);
      wr(`TMR_OFF_CTRL_A, 8'h00);
      chk(16'({wave_oe_a, wave_oe_b}), 16'h0000);
      tend("forced compare");
      wr16(`TMR_OFF_CNT_LO, 16'h0567);
      wr(`TMR_OFF_CTRL_B, 8'h40);
      u_pins.cap_pulse();
      repeat (6) step();
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0020);
      rd16(`TMR_OFF_CAP_LO, rv);
      chk(rv, 16'h0567);
      wr16(`TMR_OFF_CNT_LO, 16'h0789);
      wr(`TMR_OFF_CTRL_A, 8'h04);
      analog_cmp_out = 1'b1;
      step();
      step();
      analog_cmp_out = 1'b0;
      wr(`TMR_OFF_CTRL_A, 8'h00);
      rd16(`TMR_OFF_CAP_LO, rv);
      chk(rv, 16'h0789);
      tend("capture");
      wr(`TMR_OFF_FLAGS, 8'hFF);
      wr16(`TMR_OFF_CAP_LO, 16'h0005);
      wr16(`TMR_OFF_CNT_LO, 16'h0000);
      wr(`TMR_OFF_CTRL_B, 8'h59);
      u_pins.cap_pulse();
      repeat (6) step();
      wr(`TMR_OFF_CTRL_B, 8'h00);
      rd(`TMR_OFF_FLAGS, d8);
      chk(16'(d8), 16'h0024);
      rd16(`TMR_OFF_CAP_LO, rv);
      chk(rv, 16'h0005);
      tend("capture top");
      for (int s = 6; s < 8; s++) begin
         wr16(`TMR_OFF_CNT_LO, 16'h0000);
         wr(`TMR_OFF_CTRL_B, 8'(s));
         u_pins.pulses(10);
         repeat (6) step();
         wr(`TMR_OFF_CTRL_B, 8'h00);
         rd16(`TMR_OFF_CNT_LO, rv);
         chk(rv, 16'h000A);
      end
      tend("pin clock");
      final_report();
   end
endmodule // testbench
`default_nettype wire

// ### sim/tmr_pin_model.sv
// Far-side pin model: count pin pulses and capture pin edges
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
   input wire logic clk_sys,
   output logic count_input_pin,
   output logic capture_input_pin
);
   initial begin
      count_input_pin = 1'b0;
      capture_input_pin = 1'b0;
   end

   // Levels held 4 cycles, well above the one-cycle sampling limit
   // Pin is driven as an output would drive it; counting must follow
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         #1 count_input_pin = 1'b1;
         repeat (4) @(posedge clk_sys);
         #1 count_input_pin = 1'b0;
         repeat (3) @(posedge clk_sys);
      end
   endtask

   // One rising edge on the capture pin, then back low
   task automatic cap_pulse();
      @(posedge clk_sys);
      #1 capture_input_pin = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 capture_input_pin = 1'b0;
   endtask
endmodule // tmr_pin_model
`default_nettype wire
